// ### shscp_device.sv
// Purpose: device end of the serial command port
// Assumes: link pins asynchronous to clock_i; host keeps packet layout
// Notes:   link sampled by clock_i, edges found after two flops
// Summary of operation
// [R1] no enables: increment, roll top to bottom
// [R2] first enable: wrap sample0 high to status
// [R3] second enable: wrap sample1 high to status
// [R4] both enables: wrap timestamp top to status
// [R5] 32-bit packets, device is client
// [R6] clock idles low, sample rise, shift fall
// [R7] most significant bit first
// [R8] command packet, reply in next packet
// [R9] ignore pins while deselected
// [R10] register packet: cmd, zeros, addr, data, crc
// [R11] sensor packet: cmd, zeros, crc
// [R12] odd command is sensor request, tag upper bits
// [R13] zero and even odd-pairs are reserved
// [R14] 1000 write, 1100 read register
// [R15] serve channel whose tag matches
// [R16] sequential access advances address by one
// [R17] read reply follows unless error
// [R18] exactly 32 edges or protocol error
`timescale 1ns/1ps
module shscp_device
    import shscp_pkg::*;
#(
    parameter int N_CHAN = 2
) (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    shscp_link_if.device     link,
    input  wire logic [11:0] sample0_i,
    input  wire logic [11:0] sample1_i,
    input  wire logic [31:0] timestamp_i,
    input  wire logic [7:0]  status_i,
    input  wire logic        seq_step_i,
    input  wire logic        seq_load_i,
    input  wire logic [7:0]  seq_addr_i,
    output logic      [7:0]  seq_data_o,
    output logic      [7:0]  seq_addr_o,
    output logic             proto_err_o,
    output logic      [1:0]  wrap_enables_o
);
    logic [2:0]  sclk_sy;
    logic [2:0]  sel_sy;
    logic [1:0]  mosi_sy;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    logic [5:0]  edge_cnt;
    logic [31:0] reply;
    logic [7:0]  source_select_config_a;
    logic [7:0]  source_select_config_b;
    logic [7:0]  seq_addr;
    logic [7:0]  next_seq_addr;
    logic        miso_q;
    logic        rise;
    logic        fall;
    logic        sel_start;
    logic        sel_end;
    logic [31:0] next_reply;
    logic [3:0]  cmd;
    logic [2:0]  requested_source_tag;

    // second flop feeds the edge logic, first flop is read by nothing else
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_sy <= 3'h0;
            sel_sy  <= 3'h7;
            mosi_sy <= 2'h0;
        end else begin
            sclk_sy <= {sclk_sy[1:0], link.sclk};
            sel_sy  <= {sel_sy[1:0], link.sel_n};
            mosi_sy <= {mosi_sy[0], link.mosi};
        end
    end

    // [R9] edges count only while selected
    assign rise      = !sel_sy[1] && sclk_sy[1] && !sclk_sy[2];
    assign fall      = !sel_sy[1] && !sclk_sy[1] && sclk_sy[2];
    assign sel_start = !sel_sy[1] && sel_sy[2];
    assign sel_end   = sel_sy[1] && !sel_sy[2];
    assign cmd       = shift_in[CMD_HI:CMD_LO];
    assign requested_source_tag = cmd[3:1];

    // read view of the register map
    function automatic logic [7:0] reg_read(input logic [7:0] a);
        unique case (a)
            ADDR_SRC_A:   reg_read = source_select_config_a;
            ADDR_SRC_B:   reg_read = source_select_config_b;
            ADDR_STATUS:  reg_read = status_i;
            8'h62:        reg_read = sample0_i[7:0];
            ADDR_S0_HIGH: reg_read = {4'h0, sample0_i[11:8]};
            8'h64:        reg_read = sample1_i[7:0];
            ADDR_S1_HIGH: reg_read = {4'h0, sample1_i[11:8]};
            8'h66:        reg_read = timestamp_i[7:0];
            8'h67:        reg_read = timestamp_i[15:8];
            8'h68:        reg_read = timestamp_i[23:16];
            ADDR_TS_TOP:  reg_read = timestamp_i[31:24];
            default:      reg_read = BYTE_ZERO;
        endcase
    endfunction

    // decode a complete command into the next reply word
    always_comb begin
        // [R13] zero and reserved codes get the error reply
        next_reply = {CMD_ERROR, ST_ERROR, 26'h0};
        if (cmd[0]) begin
            // [R12] odd codes: sensor request
            // [R15] match channel tag
            if (source_select_config_a[TAG_HI:TAG_LO] == requested_source_tag)
                next_reply = {cmd, ST_OK, sample0_i, 14'h0};
            else if (source_select_config_b[TAG_HI:TAG_LO] == requested_source_tag)
                next_reply = {cmd, ST_OK, sample1_i, 14'h0};
        end else if (cmd == CMD_REG_READ) begin
            // [R14] read reply data
            // [R17] answered in next frame
            next_reply = {cmd, ST_OK, 2'h0, shift_in[ADDR_HI:ADDR_LO],
                          reg_read(shift_in[ADDR_HI:ADDR_LO]), BYTE_ZERO};
        end else if (cmd == CMD_REG_WRITE) begin
            next_reply = {cmd, ST_OK, 2'h0, shift_in[ADDR_HI:ADDR_LO],
                          shift_in[WDAT_HI:WDAT_LO], BYTE_ZERO};
        end
    end

    // [R6] sample on rise; [R7] msb enters first
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_in <= WORD_ZERO;
            edge_cnt <= 6'h00;
        end else if (sel_start) begin
            edge_cnt <= 6'h00;
        end else if (rise) begin
            shift_in <= {shift_in[30:0], mosi_sy[1]};
            edge_cnt <= (edge_cnt == 6'h3f) ? edge_cnt : 6'(edge_cnt + 6'h01);
        end
    end

    // [R18] frame checked at deselect; bad count sets error
    // [R8] reply loaded for the following frame
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reply       <= WORD_ZERO;
            proto_err_o <= 1'b0;
        end else if (sel_end) begin
            if (edge_cnt == FRAME_COUNT) begin
                reply       <= next_reply;
                proto_err_o <= 1'b0;
            end else begin
                reply       <= {CMD_ERROR, ST_ERROR, 26'h0};
                proto_err_o <= 1'b1;
            end
        end
    end

    // [R14] register write, only on a good frame
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_select_config_a <= SRC_A_RESET;
            source_select_config_b <= SRC_B_RESET;
        end else if (sel_end && edge_cnt == FRAME_COUNT && cmd == CMD_REG_WRITE) begin
            if (shift_in[ADDR_HI:ADDR_LO] == ADDR_SRC_A)
                source_select_config_a <= shift_in[WDAT_HI:WDAT_LO];
            if (shift_in[ADDR_HI:ADDR_LO] == ADDR_SRC_B)
                source_select_config_b <= shift_in[WDAT_HI:WDAT_LO];
        end
    end

    // [R5] device only answers, never drives the clock
    // [R6] output changes on fall; first bit ready at select
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_out <= WORD_ZERO;
            miso_q    <= 1'b0;
        end else if (sel_start) begin
            shift_out <= {reply[30:0], 1'b0};
            miso_q    <= reply[31];
        end else if (fall) begin
            shift_out <= {shift_out[30:0], 1'b0};
            miso_q    <= shift_out[31];
        end
    end
    assign link.miso = miso_q;

    shscp_wrap_addr u_shscp_wrap_addr (
        .addr_i               (seq_addr),
        .first_wrap_enable_i  (source_select_config_a[WRAP_EN_BIT]),
        .second_wrap_enable_i (source_select_config_b[WRAP_EN_BIT]),
        .next_addr_o          (next_seq_addr)
    );

    // [R16] sequential reads step the address by one, with wrap
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_addr   <= ADDR_BOTTOM;
            seq_data_o <= BYTE_ZERO;
        end else if (seq_load_i) begin
            seq_addr   <= seq_addr_i;
            seq_data_o <= reg_read(seq_addr_i);
        end else if (seq_step_i) begin
            seq_addr   <= next_seq_addr;
            seq_data_o <= reg_read(next_seq_addr);
        end
    end

    // registered copies for the user side
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_addr_o     <= ADDR_BOTTOM;
            wrap_enables_o <= 2'h0;
        end else begin
            seq_addr_o     <= seq_load_i ? seq_addr_i : (seq_step_i ? next_seq_addr : seq_addr);
            wrap_enables_o <= {source_select_config_b[WRAP_EN_BIT],
                               source_select_config_a[WRAP_EN_BIT]};
        end
    end
endmodule

// ### shscp_pkg.sv
// Purpose: shared constants for the serial command port (device and host ends)
// Assumes: 32-bit frames, mode 0, msb first
// Notes:   register offsets, command codes, field positions and wrap points
package shscp_pkg;
    localparam int          FRAME_BITS    = 32;
    localparam int          CNT_W         = 6;
    localparam logic [5:0]  FRAME_COUNT   = 6'h20;
    // command field and packet layout
    localparam int          CMD_HI        = 31;
    localparam int          CMD_LO        = 28;
    localparam int          FIX_HI        = 27;
    localparam int          FIX_LO        = 24;
    localparam int          ADDR_HI       = 23;
    localparam int          ADDR_LO       = 16;
    localparam int          WDAT_HI       = 15;
    localparam int          WDAT_LO       = 8;
    localparam int          CRC_HI        = 7;
    localparam int          CRC_LO        = 0;
    localparam logic [3:0]  CMD_UNUSED    = 4'h0;
    localparam logic [3:0]  CMD_REG_WRITE = 4'h8;
    localparam logic [3:0]  CMD_REG_READ  = 4'hc;
    localparam logic [3:0]  CMD_ERROR     = 4'h0;
    localparam logic [1:0]  ST_ERROR      = 2'h3;
    localparam logic [1:0]  ST_OK         = 2'h0;
    // register offsets
    localparam logic [7:0]  ADDR_SRC_A    = 8'h1a;
    localparam logic [7:0]  ADDR_SRC_B    = 8'h1b;
    localparam logic [7:0]  ADDR_STATUS   = 8'h61;
    localparam logic [7:0]  ADDR_S0_HIGH  = 8'h63;
    localparam logic [7:0]  ADDR_S1_HIGH  = 8'h65;
    localparam logic [7:0]  ADDR_TS_TOP   = 8'h69;
    localparam logic [7:0]  ADDR_TOP      = 8'hff;
    localparam logic [7:0]  ADDR_BOTTOM   = 8'h00;
    // fields of the source select registers
    localparam int          WRAP_EN_BIT   = 7;
    localparam int          TAG_HI        = 2;
    localparam int          TAG_LO        = 0;
    localparam logic [7:0]  SRC_A_RESET   = 8'h00;
    localparam logic [7:0]  SRC_B_RESET   = 8'h01;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
endpackage

// ### shscp_link_if.sv
// Purpose: four-wire link between the host end and the device end
// Assumes: host drives clock, select and data out; device drives data in
// Notes:   plain wires, no clocking block
`timescale 1ns/1ps
interface shscp_link_if;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic miso;
    modport host   (output sclk, output sel_n, output mosi, input miso);
    modport device (input sclk, input sel_n, input mosi, output miso);
endinterface

// ### shscp_wrap_addr.sv
// Purpose: next read address with sensor data wrap-around
// Assumes: combinational, same clock as its user
// Notes:   used for sequential register reads
`timescale 1ns/1ps
module shscp_wrap_addr
    import shscp_pkg::*;
(
    input  wire logic [7:0] addr_i,
    input  wire logic       first_wrap_enable_i,
    input  wire logic       second_wrap_enable_i,
    output logic      [7:0] next_addr_o
);
    // pick the wrap point from the two enables
    always_comb begin
        next_addr_o = 8'(addr_i + 8'h01);
        unique case ({second_wrap_enable_i, first_wrap_enable_i})
            2'b00: begin
                // [R1] plain increment with rollover
                next_addr_o = (addr_i == ADDR_TOP) ? ADDR_BOTTOM : 8'(addr_i + 8'h01);
            end
            2'b01: begin
                // [R2] wrap after first sample
                if (addr_i == ADDR_S0_HIGH) next_addr_o = ADDR_STATUS;
            end
            2'b10: begin
                // [R3] wrap after second sample
                if (addr_i == ADDR_S1_HIGH) next_addr_o = ADDR_STATUS;
            end
            2'b11: begin
                // [R4] wrap after timestamp top
                if (addr_i == ADDR_TS_TOP) next_addr_o = ADDR_STATUS;
            end
        endcase
    end
endmodule

// ### shscp_host.sv
// Purpose: host end, makes clock and select, sends one 32-bit frame per request
// Assumes: user builds a legal command word
// Notes:   link clock divided from clock_i; half period must be six clocks or more,
//          since the device answer crosses two synchronisers on its way back
`timescale 1ns/1ps
module shscp_host
    import shscp_pkg::*;
#(
    parameter int HALF_DIV = 8
) (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    shscp_link_if.host       link,
    input  wire logic        start_i,
    input  wire logic [31:0] tx_word_i,
    output logic             busy_o,
    output logic             done_o,
    output logic      [31:0] rx_word_o
);
    typedef enum logic [1:0] {
        SHSCP_IDLE = 2'b00,
        SHSCP_LEAD = 2'b01,
        SHSCP_SHIFT = 2'b10,
        SHSCP_TAIL = 2'b11
    } shscp_state_t;
    shscp_state_t state;
    logic [7:0]  div;
    logic [5:0]  bits;
    logic [31:0] txs;
    logic [31:0] rxs;
    logic [1:0]  miso_sy;
    logic        sclk_q;
    logic        sel_q;
    logic        tick;

    assign tick = (div == 8'(HALF_DIV - 1));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) miso_sy <= 2'h0;
        else           miso_sy <= {miso_sy[0], link.miso};
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) div <= 8'h00;
        else           div <= (tick || state == SHSCP_IDLE) ? 8'h00 : 8'(div + 8'h01);
    end

    // [R5] [R6] host makes the idle-low clock; [R7] msb first; [R10] [R11] word from user
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= SHSCP_IDLE;
            sclk_q <= 1'b0;
            sel_q <= 1'b1;
            txs <= WORD_ZERO;
            rxs <= WORD_ZERO;
            bits <= 6'h00;
            done_o <= 1'b0;
            rx_word_o <= WORD_ZERO;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                SHSCP_IDLE: if (start_i) begin
                    sel_q <= 1'b0;
                    txs <= tx_word_i;
                    bits <= 6'h00;
                    state <= SHSCP_LEAD;
                end
                SHSCP_LEAD: if (tick) begin
                    // first rise ends the lead-in, one half period after select
                    sclk_q <= 1'b1;
                    rxs <= {rxs[30:0], miso_sy[1]};
                    bits <= 6'(bits + 6'h01);
                    state <= SHSCP_SHIFT;
                end
                SHSCP_SHIFT: if (tick) begin
                    if (!sclk_q) begin
                        sclk_q <= 1'b1;
                        rxs <= {rxs[30:0], miso_sy[1]};
                        bits <= 6'(bits + 6'h01);
                    end else begin
                        sclk_q <= 1'b0;
                        txs <= {txs[30:0], 1'b0};
                        if (bits == FRAME_COUNT) state <= SHSCP_TAIL;
                    end
                end
                SHSCP_TAIL: if (tick) begin
                    // [R8] reply of previous command arrives here
                    sel_q <= 1'b1;
                    rx_word_o <= rxs;
                    done_o <= 1'b1;
                    state <= SHSCP_IDLE;
                end
            endcase
        end
    end
    assign link.sclk  = sclk_q;
    assign link.sel_n = sel_q;
    assign link.mosi  = txs[31];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) busy_o <= 1'b0;
        else           busy_o <= (state != SHSCP_IDLE) || start_i;
    end
endmodule

// ### shscp_link_properties.sv
// Purpose: wire-level checks on the link between host and device ends
// Assumes: one clock_i domain; host built with a half period of 8 cycles
// Notes:   link seen through clock_i samples, so its edges show a cycle late
`timescale 1ns/1ps
module shscp_link_properties
    import shscp_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic arst_n_i,
    input  wire logic sclk,
    input  wire logic sel_n,
    input  wire logic mosi,
    input  wire logic miso
);
    logic [5:0] rise_cnt;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    // rises inside the current frame; cleared while deselected so noise cannot pile up
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_cnt <= 6'h00;
        end else if (sel_n) begin
            rise_cnt <= 6'h00;
        end else if ($rose(sclk)) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end

    // high half and lead-in, each eight clock_i cycles
    sequence s_high_half;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence s_lead;
        !sclk [*8] ##1 sclk;
    endsequence

    property p_idle_low; sel_n |-> !sclk; endproperty
    property p_mosi_hold; (!sel_n && sclk && $past(sclk)) |-> $stable(mosi); endproperty
    property p_miso_hold; (!sel_n && sclk && $past(sclk)) |-> $stable(miso); endproperty
    property p_high_half; $rose(sclk) |-> s_high_half; endproperty
    property p_low_half; ($fell(sclk) && !sel_n) |-> !sclk [*8]; endproperty
    property p_lead; $fell(sel_n) |-> s_lead; endproperty
    property p_edge_count; $rose(sel_n) |-> rise_cnt == FRAME_COUNT; endproperty
    property p_count_cap; rise_cnt <= FRAME_COUNT; endproperty
    property p_rise_selected; $rose(sclk) |-> !sel_n; endproperty
    property p_frame_len; $fell(sel_n) |-> ##[512:528] $rose(sel_n); endproperty

    a_idle_low: assert property (p_idle_low)
        else $error("link clock high while deselected");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("host data moved while link clock high");
    a_miso_hold: assert property (p_miso_hold)
        else $error("device data moved while link clock high");
    a_high_half: assert property (p_high_half)
        else $error("link clock high half not eight cycles");
    a_low_half: assert property (p_low_half)
        else $error("link clock low half too short");
    a_lead: assert property (p_lead)
        else $error("first rise not eight cycles after select");
    a_edge_count: assert property (p_edge_count)
        else $error("frame ended without 32 rises");
    a_count_cap: assert property (p_count_cap)
        else $error("more than 32 rises in one frame");
    a_rise_selected: assert property (p_rise_selected)
        else $error("link clock rose while deselected");
    a_frame_len: assert property (p_frame_len)
        else $error("frame length out of range");
endmodule

// ### tb_sensor_host_serial_command_port.sv
// Purpose: self-checking bench, host and device ends joined on one link
// Assumes: a second device faces a bench driver that can break framing
// Notes:   replies are judged one frame late, as the link returns them
`timescale 1ns/1ps
module tb_sensor_host_serial_command_port
    import shscp_pkg::*;
;
    localparam logic [31:0] ERR_WORD = 32'h0c00_0000;
    logic        clock_i;
    logic        arst_n_i;
    logic        start_i;
    logic [31:0] tx_word_i;
    logic        busy;
    logic        done;
    logic [31:0] rx_word;
    logic [11:0] sample0 = 12'h5a3;
    logic [11:0] sample1 = 12'hc4e;
    logic [31:0] stamp   = 32'h1234_5678;
    logic [7:0]  status  = 8'h3c;
    logic        seq_load;
    logic        seq_step;
    logic [7:0]  seq_addr;
    logic [7:0]  seq_data;
    logic [7:0]  seq_at;
    logic        perr;
    logic [1:0]  wraps;
    logic        perr_b;
    logic [1:0]  wraps_b;
    logic [31:0] pend;
    logic        have_pend;
    logic [31:0] rx_b;
    logic [2:0]  tg;
    logic [1:0]  cfg;
    int          err_total;
    int          checked;
    logic [3:0]  rsv [6]       = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
    logic [7:0]  wrap_from [4] = '{8'hff, 8'h63, 8'h65, 8'h69};
    logic [7:0]  wrap_to [4]   = '{8'h00, 8'h61, 8'h61, 8'h61};

    shscp_link_if link_a ();
    shscp_link_if link_b ();
    shscp_host #(.HALF_DIV(8)) u_shscp_host (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .link(link_a), .start_i(start_i), .tx_word_i(tx_word_i), .busy_o(busy),
        .done_o(done), .rx_word_o(rx_word));
    shscp_device u_shscp_device (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link_a),
        .sample0_i(sample0), .sample1_i(sample1), .timestamp_i(stamp), .status_i(status),
        .seq_step_i(seq_step), .seq_load_i(seq_load), .seq_addr_i(seq_addr),
        .seq_data_o(seq_data), .seq_addr_o(seq_at), .proto_err_o(perr), .wrap_enables_o(wraps));
    // second device faces the bench driver, which may break framing on purpose
    shscp_device u_shscp_device_b (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link_b),
        .sample0_i(sample0), .sample1_i(sample1), .timestamp_i(stamp), .status_i(status),
        .seq_step_i(seq_step), .seq_load_i(seq_load), .seq_addr_i(seq_addr),
        .seq_data_o(), .seq_addr_o(), .proto_err_o(perr_b), .wrap_enables_o(wraps_b));
    shscp_link_properties u_shscp_link_properties (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .sclk(link_a.sclk), .sel_n(link_a.sel_n), .mosi(link_a.mosi), .miso(link_a.miso));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one host frame; the reply seen now belongs to the frame before
    task automatic frame(input logic [31:0] word, input logic [31:0] exp);
        int n;
        @(posedge clock_i);
        #1 start_i = 1'b1;
        tx_word_i = word;
        @(posedge clock_i);
        #1 start_i = 1'b0;
        check(32'(busy), 32'h1);
        n = 0;
        while (done !== 1'b1) begin
            @(posedge clock_i);
            #1 n++;
            if (n > 1000) begin
                err_total++;
                end_sim();
            end
        end
        if (have_pend) check(rx_word, pend);
        pend = exp;
        have_pend = 1'b1;
    endtask

    // load an address, optionally step once, then compare where it landed
    task automatic seq_go(input logic [7:0] a, input logic step, input logic [7:0] exp);
        @(posedge clock_i);
        #1 seq_load = 1'b1;
        seq_addr = a;
        @(posedge clock_i);
        #1 seq_load = 1'b0;
        seq_step = step;
        @(posedge clock_i);
        #1 seq_step = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 check(32'(seq_at), 32'(exp));
    endtask

    // bench as host on the second link, 125 ns clock; data released inverted after
    task automatic bang(input int nbits, input logic [31:0] word);
        link_b.sel_n = 1'b0;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            link_b.mosi = word[31-i];
            #62.5 link_b.sclk = 1'b1;
            rx_b = {rx_b[30:0], link_b.miso};
            #62.5 link_b.sclk = 1'b0;
        end
        #62.5 link_b.sel_n = 1'b1;
        link_b.mosi = ~link_b.mosi;
        repeat (8) @(posedge clock_i);
    endtask

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // watchdog, in case a handshake never comes
    initial begin
        repeat (60000) @(posedge clock_i);
        err_total++;
        end_sim();
    end

    initial begin
        {arst_n_i, start_i, tx_word_i, seq_load, seq_step, seq_addr} = '0;
        {link_b.sclk, link_b.mosi, link_b.sel_n} = 3'b001;
        err_total = 0;
        checked = 0;
        have_pend = 1'b0;
        repeat (4) @(posedge clock_i);
        #1 arst_n_i = 1'b1;
        // every tag on both channels, tags kept distinct so only one matches
        for (int t = 0; t < 8; t++) begin
            tg = 3'(t);
            frame({16'h801a, 5'h0, tg, 8'h0}, {16'h801a, 5'h0, tg, 8'h0});
            frame({16'h801b, 5'h0, ~tg, 8'h0}, {16'h801b, 5'h0, ~tg, 8'h0});
            frame({tg, 1'b1, 28'h0}, {tg, 1'b1, 2'h0, sample0, 14'h0});
            frame({~tg, 1'b1, 28'h0}, {~tg, 1'b1, 2'h0, sample1, 14'h0});
        end
        // all four wrap settings, set over the link and read back
        for (int c = 0; c < 4; c++) begin
            cfg = 2'(c);
            frame({16'h801a, cfg[0], 15'h0}, {16'h801a, cfg[0], 15'h0});
            frame({16'h801b, cfg[1], 15'h0}, {16'h801b, cfg[1], 15'h0});
            frame(32'hc01b_0000, {16'hc01b, cfg[1], 15'h0});
            check(32'(wraps), 32'(cfg));
            seq_go(wrap_from[c], 1'b1, wrap_to[c]);
            seq_go(8'h61, 1'b1, 8'h62);
        end
        seq_go(8'h61, 1'b0, 8'h61);
        check(32'(seq_data), 32'(status));
        frame(32'h8061_a500, 32'h8061_a500);
        frame(32'hc061_0000, {16'hc061, status, 8'h00});
        foreach (rsv[i]) frame({rsv[i], 28'h0}, ERR_WORD);
        // last wrap setting left bit 7 of the first select register set
        frame(32'hc01a_0000, 32'hc01a_8000);
        // both tags are zero now: tag one finds no channel, tag zero the first
        frame(32'h3000_0000, ERR_WORD);
        frame(32'h1000_0000, {4'h1, 2'h0, sample0, 14'h0});
        // one more frame brings back the reply to the sensor request above
        frame(32'hc01b_0000, 32'hc01b_8000);
        check(32'(perr), 32'h0);
        // noise while deselected, then a short frame, then a good one
        repeat (4) begin
            #62.5 link_b.sclk = ~link_b.sclk;
            link_b.mosi = ~link_b.mosi;
        end
        bang(31, 32'h801b_8000);
        check(32'(perr_b), 32'h1);
        check(32'(wraps_b), 32'h0);
        bang(32, 32'h801a_8000);
        check(rx_b, ERR_WORD);
        check(32'(perr_b), 32'h0);
        check(32'(wraps_b), 32'h1);
        bang(32, 32'h1000_0000);
        check(rx_b, 32'h801a_8000);
        end_sim();
    end
endmodule
